// >>> rtl/regbuf_defines.vh
// Constants for the configurable registered buffer: fields, masks, timing
`ifndef REGBUF_DEFINES_VH
`define REGBUF_DEFINES_VH

// ********************************************************************
// Pin sampling vector: bit positions of each pin in the sync chain
// ********************************************************************
`define SYNC_W 32
`define S_CLK 31
`define S_WIDTH 30
`define S_PLACE 29
`define S_PRI 28
`define S_SEC 27
`define S_ODT 26
`define S_CKE 25

// ********************************************************************
// Captured word: fields stored per clock edge of the memory clock
// ********************************************************************
`define WORD_W 31
`define F_WIDTH 30
`define F_PLACE 29
`define F_GATE 28
`define F_CS 27
`define F_ODT 26
`define F_CKE 25
`define DATA_W 25
`define HALF_W 14

// ********************************************************************
// Active data lines per configuration (bit k is line k+1)
// ********************************************************************
`define MASK_ONE 25'h1ffffb6
`define MASK_A 14'h3fb6
`define MASK_B 14'h1bbf

// ********************************************************************
// Timing: receiver enable time after reset release
// ********************************************************************
`define REF_PERIOD_NS 50
`define RX_EN_TIME_NS 150
`define RX_EN_CYCLES ((`RX_EN_TIME_NS + `REF_PERIOD_NS - 1) / `REF_PERIOD_NS)
`define RX_CNT_W 3

`endif

// >>> rtl/word_buffer.v
// Two-entry buffer with valid and ready on both sides
`default_nettype none

module word_buffer #(
   parameter WIDTH = 31,
   parameter DEPTH = 2
) (
   input wire i_clk,
   input wire i_reset_n,
   input wire i_in_valid,
   output wire o_in_ready,
   input wire [WIDTH-1:0] i_in_data,
   output wire o_out_valid,
   input wire i_out_ready,
   output wire [WIDTH-1:0] o_out_data
);

   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg wr_ptr_q;
   reg rd_ptr_q;
   reg [1:0] count_q;
   wire push;
   wire pop;

   // Full and empty come straight from the occupancy count
   assign o_in_ready = (count_q != 2'h2);
   assign o_out_valid = (count_q != 2'h0);
   assign o_out_data = mem[rd_ptr_q];
   assign push = i_in_valid & o_in_ready;
   assign pop = o_out_valid & i_out_ready;

   // Storage has no reset; the count guards every read
   always @(posedge i_clk) begin
      if (push) begin
         mem[wr_ptr_q] <= i_in_data;
      end
   end

   // Pointers and count
   always @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         wr_ptr_q <= 1'b0;
         rd_ptr_q <= 1'b0;
         count_q <= 2'h0;
      end else begin
         if (push) begin
            wr_ptr_q <= ~wr_ptr_q;
         end
         if (pop) begin
            rd_ptr_q <= ~rd_ptr_q;
         end
         if (push && !pop) begin
            count_q <= count_q + 2'h1;
         end else if (pop && !push) begin
            count_q <= count_q - 2'h1;
         end
      end
   end

endmodule
`default_nettype wire

// >>> rtl/regbuf_top.v
// Configurable registered buffer for memory address and command lines
`default_nettype none
`include "regbuf_defines.vh"

// Function
// - Capture all active inputs on rising edge of the true memory clock.
// - Width select low: 25-bit one-to-one; high: 14-bit one-to-two.
// - In one-to-two, placement select low picks A lines, high picks B.
// - While reset is low, all registers but the buffer storage clear and every output is low.
// - During reset, samplers are off; floating inputs do nothing.
// - Reset acts asynchronously; registers clear without a clock edge.
// - After release, outputs stay low until the receivers are enabled.
// - Both chip selects high: gated data outputs hold their values.
// - Either chip select low: gated data outputs follow the registers.
// - Reset overrides chip-select gating, forcing all outputs low.
// - Select, termination and clock-enable outputs ignore the gating.
// - One-to-one mode gates data lines 2, 3, 5, 6 and 8 through 25.
module regbuf_top (
   input wire I_REF_CLK,
   input wire I_RESET_N,
   input wire I_DIFF_CLOCK_TRUE,
   input wire I_PLACEMENT_SELECT,
   input wire I_WIDTH_SELECT,
   input wire I_PRIMARY_SELECT_N,
   input wire I_SECONDARY_SELECT_N,
   input wire [24:0] I_DATA_IN_LINE,
   input wire I_TERMINATION_IN,
   input wire I_CLK_ENABLE_IN,
   input wire I_LOAD_READY,
   output reg [24:0] O_GATED_DATA_OUT,
   output reg [13:0] O_GATED_DATA_OUT_A,
   output reg [13:0] O_GATED_DATA_OUT_B,
   output reg O_SELECT_OUT,
   output reg O_SELECT_OUT_A,
   output reg O_SELECT_OUT_B,
   output reg O_TERMINATION_OUT,
   output reg O_TERMINATION_OUT_A,
   output reg O_TERMINATION_OUT_B,
   output reg O_CLK_ENABLE_OUT,
   output reg O_CLK_ENABLE_OUT_A,
   output reg O_CLK_ENABLE_OUT_B,
   output reg O_WORD_VALID,
   output reg O_CAPTURE_READY,
   output reg O_OVERRUN
);

   // *****************************************************************
   // Pin sampling
   // *****************************************************************
   wire [`SYNC_W-1:0] pins;
   reg [`SYNC_W-1:0] s1_q;
   reg [`SYNC_W-1:0] s2_q;
   reg [`SYNC_W-1:0] s3_q;
   reg [`SYNC_W-1:0] filt_q;
   wire [`SYNC_W-1:0] filt_d;
   reg [`RX_CNT_W-1:0] rx_cnt_q;
   reg rx_on_q;

   assign pins = {I_DIFF_CLOCK_TRUE, I_WIDTH_SELECT, I_PLACEMENT_SELECT,
                  I_PRIMARY_SELECT_N, I_SECONDARY_SELECT_N,
                  I_TERMINATION_IN, I_CLK_ENABLE_IN, I_DATA_IN_LINE};

   // A change counts only once stages two and three agree
   assign filt_d = (s2_q & s3_q) | (filt_q & (s2_q | s3_q));

   // Three-stage sampler, cleared by reset so floating pins are ignored
   always @(posedge I_REF_CLK or negedge I_RESET_N) begin
      if (!I_RESET_N) begin
         s1_q <= {`SYNC_W{1'b0}};
         s2_q <= {`SYNC_W{1'b0}};
         s3_q <= {`SYNC_W{1'b0}};
         filt_q <= {`SYNC_W{1'b0}};
      end else begin
         s1_q <= pins;
         s2_q <= s1_q;
         s3_q <= s2_q;
         filt_q <= filt_d;
      end
   end

   // Receivers come on only after the enable time; stale samples never
   // reach the outputs, which keeps them low across the release
   always @(posedge I_REF_CLK or negedge I_RESET_N) begin
      if (!I_RESET_N) begin
         rx_cnt_q <= {`RX_CNT_W{1'b0}};
         rx_on_q <= 1'b0;
      end else if (!rx_on_q) begin
         rx_cnt_q <= rx_cnt_q + {{(`RX_CNT_W-1){1'b0}}, 1'b1};
         if (rx_cnt_q == `RX_EN_CYCLES - 1) begin
            rx_on_q <= 1'b1;
         end
      end
   end

   // *****************************************************************
   // Capture on the rising edge of the memory clock
   // *****************************************************************
   wire clk_rise;
   reg [`WORD_W-1:0] cap_word_q;
   reg cap_valid_q;
   wire buf_in_ready;
   wire buf_out_valid;
   wire [`WORD_W-1:0] buf_out_word;
   wire pop;

   assign clk_rise = filt_d[`S_CLK] & ~filt_q[`S_CLK] & rx_on_q;

   // Gate bit set only when both selects are high; mode travels with data
   always @(posedge I_REF_CLK or negedge I_RESET_N) begin
      if (!I_RESET_N) begin
         cap_word_q <= {`WORD_W{1'b0}};
         cap_valid_q <= 1'b0;
         O_OVERRUN <= 1'b0;
      end else begin
         if (clk_rise) begin
            cap_word_q <= {filt_d[`S_WIDTH], filt_d[`S_PLACE],
                           filt_d[`S_PRI] & filt_d[`S_SEC],
                           filt_d[`S_PRI],
                           filt_d[`S_ODT], filt_d[`S_CKE],
                           filt_d[`DATA_W-1:0]};
            cap_valid_q <= 1'b1;
         end else if (buf_in_ready) begin
            cap_valid_q <= 1'b0;
         end
         // Sticky: a held word was replaced before the buffer took it
         if (clk_rise && cap_valid_q && !buf_in_ready) begin
            O_OVERRUN <= 1'b1;
         end
      end
   end

   // *****************************************************************
   // Buffer between capture and the output drivers
   // *****************************************************************
   word_buffer #(
      .WIDTH(`WORD_W),
      .DEPTH(2)
   ) u_word_buffer (
      .i_clk(I_REF_CLK),
      .i_reset_n(I_RESET_N),
      .i_in_valid(cap_valid_q),
      .o_in_ready(buf_in_ready),
      .i_in_data(cap_word_q),
      .o_out_valid(buf_out_valid),
      .i_out_ready(pop),
      .o_out_data(buf_out_word)
   );

   // Drain when the load side takes the current word or none is shown
   assign pop = buf_out_valid & (I_LOAD_READY | ~O_WORD_VALID);

   // Ready toward the controller, a cycle late, mirrors buffer space
   always @(posedge I_REF_CLK or negedge I_RESET_N) begin
      if (!I_RESET_N) begin
         O_CAPTURE_READY <= 1'b0;
      end else begin
         O_CAPTURE_READY <= buf_in_ready & rx_on_q;
      end
   end

   // *****************************************************************
   // Output stage
   // *****************************************************************
   wire w_two;
   wire w_place;
   wire w_gate;
   wire [`DATA_W-1:0] w_data;
   wire [`HALF_W-1:0] half_mask;
   wire [`HALF_W-1:0] half_data;

   assign w_two = buf_out_word[`F_WIDTH];
   assign w_place = buf_out_word[`F_PLACE];
   assign w_gate = buf_out_word[`F_GATE];
   assign w_data = buf_out_word[`DATA_W-1:0];
   assign half_mask = w_place ? `MASK_B : `MASK_A;
   assign half_data = w_data[`HALF_W-1:0] & half_mask;

   // Reset has priority over everything, so gating cannot hold a level
   always @(posedge I_REF_CLK or negedge I_RESET_N) begin
      if (!I_RESET_N) begin
         O_GATED_DATA_OUT <= {`DATA_W{1'b0}};
         O_GATED_DATA_OUT_A <= {`HALF_W{1'b0}};
         O_GATED_DATA_OUT_B <= {`HALF_W{1'b0}};
         O_SELECT_OUT <= 1'b0;
         O_SELECT_OUT_A <= 1'b0;
         O_SELECT_OUT_B <= 1'b0;
         O_TERMINATION_OUT <= 1'b0;
         O_TERMINATION_OUT_A <= 1'b0;
         O_TERMINATION_OUT_B <= 1'b0;
         O_CLK_ENABLE_OUT <= 1'b0;
         O_CLK_ENABLE_OUT_A <= 1'b0;
         O_CLK_ENABLE_OUT_B <= 1'b0;
         O_WORD_VALID <= 1'b0;
      end else begin
         if (pop) begin
            O_WORD_VALID <= 1'b1;
         end else if (I_LOAD_READY) begin
            O_WORD_VALID <= 1'b0;
         end
         if (pop && !w_two) begin
            // One-to-one: paired A/B outputs idle low
            if (!w_gate) begin
               O_GATED_DATA_OUT <= w_data & `MASK_ONE;
            end
            O_GATED_DATA_OUT_A <= {`HALF_W{1'b0}};
            O_GATED_DATA_OUT_B <= {`HALF_W{1'b0}};
            O_SELECT_OUT <= buf_out_word[`F_CS];
            O_TERMINATION_OUT <= buf_out_word[`F_ODT];
            O_CLK_ENABLE_OUT <= buf_out_word[`F_CKE];
            O_SELECT_OUT_A <= 1'b0;
            O_SELECT_OUT_B <= 1'b0;
            O_TERMINATION_OUT_A <= 1'b0;
            O_TERMINATION_OUT_B <= 1'b0;
            O_CLK_ENABLE_OUT_A <= 1'b0;
            O_CLK_ENABLE_OUT_B <= 1'b0;
         end else if (pop) begin
            // One-to-two: each active input feeds its A and its B copy
            O_GATED_DATA_OUT <= {`DATA_W{1'b0}};
            if (!w_gate) begin
               O_GATED_DATA_OUT_A <= half_data;
               O_GATED_DATA_OUT_B <= half_data;
            end
            O_SELECT_OUT <= 1'b0;
            O_TERMINATION_OUT <= 1'b0;
            O_CLK_ENABLE_OUT <= 1'b0;
            O_SELECT_OUT_A <= buf_out_word[`F_CS];
            O_SELECT_OUT_B <= buf_out_word[`F_CS];
            O_TERMINATION_OUT_A <= buf_out_word[`F_ODT];
            O_TERMINATION_OUT_B <= buf_out_word[`F_ODT];
            O_CLK_ENABLE_OUT_A <= buf_out_word[`F_CKE];
            O_CLK_ENABLE_OUT_B <= buf_out_word[`F_CKE];
         end
      end
   end

endmodule
`default_nettype wire

// >>> testbench/regbuf_chk.sv
// Port checker for the configurable registered buffer
`default_nettype none
module regbuf_chk (
   input wire logic I_REF_CLK,
   input wire logic I_RESET_N,
   input wire logic I_LOAD_READY,
   input wire logic [24:0] O_GATED_DATA_OUT,
   input wire logic [13:0] O_GATED_DATA_OUT_A,
   input wire logic [13:0] O_GATED_DATA_OUT_B,
   input wire logic O_SELECT_OUT,
   input wire logic O_SELECT_OUT_A,
   input wire logic O_SELECT_OUT_B,
   input wire logic O_TERMINATION_OUT,
   input wire logic O_TERMINATION_OUT_A,
   input wire logic O_TERMINATION_OUT_B,
   input wire logic O_CLK_ENABLE_OUT,
   input wire logic O_CLK_ENABLE_OUT_A,
   input wire logic O_CLK_ENABLE_OUT_B,
   input wire logic O_WORD_VALID,
   input wire logic O_CAPTURE_READY,
   input wire logic O_OVERRUN
);
   timeunit 1ns;
   timeprecision 1ps;
   // All load-facing outputs in one vector
   wire [61:0] outs = {O_GATED_DATA_OUT, O_GATED_DATA_OUT_A,
      O_GATED_DATA_OUT_B, O_SELECT_OUT, O_SELECT_OUT_A, O_SELECT_OUT_B,
      O_TERMINATION_OUT, O_TERMINATION_OUT_A, O_TERMINATION_OUT_B,
      O_CLK_ENABLE_OUT, O_CLK_ENABLE_OUT_A, O_CLK_ENABLE_OUT_B};
   default clocking @(posedge I_REF_CLK); endclocking
   // ****************************************************************
   // Reset, then the shape of every shown word
   // ****************************************************************
   // No disable here: this one must hold while reset is low
   chk_reset_clears: assert property (
      !I_RESET_N |-> outs == 62'h0 && !O_WORD_VALID && !O_OVERRUN)
      else $error("outputs not cleared in reset");
   chk_release_quiet: assert property (
      disable iff (!I_RESET_N) $rose(I_RESET_N) |-> (outs == 62'h0) [*4])
      else $error("output moved before receivers were on");
   chk_ready_late: assert property (
      disable iff (!I_RESET_N) $rose(I_RESET_N) |-> !O_CAPTURE_READY [*3])
      else $error("capture ready before receiver enable");
   chk_change_flagged: assert property (
      disable iff (!I_RESET_N) !$stable(outs) |-> O_WORD_VALID)
      else $error("outputs changed with no word shown");
   chk_word_stands: assert property (
      disable iff (!I_RESET_N)
      O_WORD_VALID && !I_LOAD_READY |=> $stable(outs) && O_WORD_VALID)
      else $error("stalled word did not stand");
   chk_pair_equal: assert property (
      disable iff (!I_RESET_N) O_GATED_DATA_OUT_A == O_GATED_DATA_OUT_B
      && O_SELECT_OUT_A == O_SELECT_OUT_B
      && O_TERMINATION_OUT_A == O_TERMINATION_OUT_B
      && O_CLK_ENABLE_OUT_A == O_CLK_ENABLE_OUT_B)
      else $error("A and B copies differ");
   chk_one_to_one: assert property (
      disable iff (!I_RESET_N) O_GATED_DATA_OUT != 25'h0 |->
      {O_GATED_DATA_OUT_A, O_SELECT_OUT_A, O_CLK_ENABLE_OUT_A} == 16'h0)
      else $error("split outputs active in wide mode");
   chk_mask_wide: assert property (
      disable iff (!I_RESET_N) (O_GATED_DATA_OUT & 25'h0000049) == 25'h0)
      else $error("unused wide line driven");
   chk_mask_split: assert property (
      disable iff (!I_RESET_N) O_GATED_DATA_OUT_A[6] == 1'b0)
      else $error("line seven driven in split mode");
   chk_overrun_sticky: assert property (
      disable iff (!I_RESET_N) O_OVERRUN |=> O_OVERRUN)
      else $error("overrun flag dropped without reset");
   // Main scenarios reached
   cover property (O_WORD_VALID && I_LOAD_READY && O_GATED_DATA_OUT_A != 0);
   cover property (O_WORD_VALID && !I_LOAD_READY);
   cover property (O_OVERRUN);
endmodule
bind regbuf_top regbuf_chk u_chk (.*);
`default_nettype wire

// >>> testbench/ctl_model.sv
// Memory controller model driving clock, data and control pins
`default_nettype none
module ctl_model (
   input wire logic clk,
   input wire logic fl,
   output wire logic [29:0] pins
);
   timeunit 1ns;
   timeprecision 1ps;
   // Clock, data, selects, termination, clock enable
   logic [29:0] r = 30'h0;
   // Floating pins while the bench holds the device in reset
   assign pins = fl ? {30{1'bz}} : r;
   // One word: setup, rise, 4 high, 2 to 4 low (prompt or slow)
   task automatic issue(input logic [24:0] v, input logic p, s, o, c);
      @(posedge clk);
      #2 r = {1'b0, v, p, s, o, c};
      @(posedge clk);
      #2 r[29] = 1'b1;
      repeat (4) @(posedge clk);
      // Lines left with junk, never the last word
      #2 r[29:4] = {1'b0, ~v};
      repeat (2 + $urandom % 3) @(posedge clk);
   endtask
endmodule
`default_nettype wire

// >>> testbench/configurable_registered_buffer_test.sv
// Self-checking bench for the configurable registered buffer
`default_nettype none
module configurable_registered_buffer_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk, rst_n, fl, w, pl, ready, chk_on;
   wire [29:0] pins;
   wire mclk, pn, sn, odt, cke, wv, cr, ov;
   wire [24:0] d, q1;
   wire [13:0] qa, qb;
   wire [8:0] qs;
   logic [61:0] exp_q[$];
   logic [24:0] e1;
   logic [13:0] e2;
   logic [31:0] r;
   int errors = 0, check_count = 0, cyc = 0;
   assign {mclk, d, pn, sn, odt, cke} = pins;
   ctl_model m (.clk(clk), .fl(fl), .pins(pins));
   regbuf_top dut (.I_REF_CLK(clk), .I_RESET_N(rst_n),
      .I_DIFF_CLOCK_TRUE(mclk), .I_PLACEMENT_SELECT(pl),
      .I_WIDTH_SELECT(w), .I_PRIMARY_SELECT_N(pn),
      .I_SECONDARY_SELECT_N(sn), .I_DATA_IN_LINE(d),
      .I_TERMINATION_IN(odt), .I_CLK_ENABLE_IN(cke),
      .I_LOAD_READY(ready), .O_GATED_DATA_OUT(q1),
      .O_GATED_DATA_OUT_A(qa), .O_GATED_DATA_OUT_B(qb),
      .O_SELECT_OUT(qs[8]), .O_SELECT_OUT_A(qs[7]), .O_SELECT_OUT_B(qs[6]),
      .O_TERMINATION_OUT(qs[5]), .O_TERMINATION_OUT_A(qs[4]),
      .O_TERMINATION_OUT_B(qs[3]), .O_CLK_ENABLE_OUT(qs[2]),
      .O_CLK_ENABLE_OUT_A(qs[1]), .O_CLK_ENABLE_OUT_B(qs[0]),
      .O_WORD_VALID(wv), .O_CAPTURE_READY(cr), .O_OVERRUN(ov));
   // ****************************************************************
   // Shared tasks
   // ****************************************************************
   task automatic check(input logic [61:0] s, e);
      check_count++;
      if (s !== e) begin
         errors++;
         $display("BAD t=%0t saw=%h exp=%h", $time, s, e);
      end
   endtask
   task automatic end_sim;
      $display("errors=%0d checks=%0d", errors, check_count);
      if (errors == 0 && check_count > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   // Note the expected word, then let the controller send it
   task automatic send(input logic [24:0] v, input logic p, s, o, c);
      if (!(p & s)) begin
         e1 = v & 25'h1ffffb6;
         e2 = v[13:0] & (pl ? 14'h1bbf : 14'h3fb6);
      end
      if (w)
         exp_q.push_back({25'h0, e2, e2, 1'b0, p, p, 1'b0, o, o, 1'b0, c, c});
      else
         exp_q.push_back({e1, 28'h0, p, 2'h0, o, 2'h0, c, 2'h0});
      m.issue(v, p, s, o, c);
   endtask
   // Bounded wait until every noted word was seen
   task automatic drain;
      for (int i = 0; i < 60 && exp_q.size() != 0; i++) @(posedge clk);
      check(62'(exp_q.size()), 62'h0);
   endtask
   // ****************************************************************
   // Clock, timeout, load stalls, output watcher
   // ****************************************************************
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   // Ceiling well above the roughly 400 cycles the tests need
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 4000) begin
         errors++;
         end_sim();
      end
   end
   always @(posedge clk)
      if (chk_on) ready <= #2 ($urandom % 4 != 0);
   // A word counts as taken when shown and the load is ready
   always @(posedge clk)
      if (rst_n && chk_on && wv && ready && exp_q.size() == 0)
         check(62'h1, 62'h0);
      else if (rst_n && chk_on && wv && ready)
         check({q1, qa, qb, qs}, exp_q.pop_front());
   // ****************************************************************
   // Main sequence
   // ****************************************************************
   initial begin
      fl = 1'b1;
      w = 1'b0;
      pl = 1'b0;
      ready = 1'b1;
      chk_on = 1'b0;
      r = $urandom(65);
      // Lowered a step after time zero so every reset process sees the edge
      #1 rst_n = 1'b0;
      @(posedge clk);
      #2 fl = 1'b0;
      @(posedge clk);
      #2 rst_n = 1'b1;
      chk_on = 1'b1;
      // Wide, split A, split B; first four words walk the select pairs
      for (int k = 0; k < 3; k++) begin
         #2 w = (k != 0);
         pl = (k == 2);
         for (int j = 0; j < 12; j++) begin
            r = $urandom;
            if (j < 4) r[31:30] = 2'(j);
            send(25'($urandom), r[31], r[30], r[29], r[28]);
         end
         drain();
      end
      // Load stalls long: buffer fills, refuses, and flags the loss
      #2 chk_on = 1'b0;
      @(posedge clk);
      #2 ready = 1'b0;
      repeat (5) m.issue(25'($urandom), 1'b0, 1'b0, 1'b1, 1'b1);
      check(62'({cr, ov}), 62'h1);
      #2 ready = 1'b1;
      m.issue(25'h0, 1'b1, 1'b1, 1'b1, 1'b1);
      for (int i = 0; i < 20 && wv; i++) @(posedge clk);
      // Drained: nothing shown, space offered again, loss still flagged
      check(62'({wv, cr, ov}), 62'h3);
      // Reset mid-cycle with both selects high, no clock edge
      #20 rst_n = 1'b0;
      #1 check({q1, qa, qb, qs}, 62'h0);
      check(62'({wv, ov}), 62'h0);
      @(posedge clk);
      #2 rst_n = 1'b1;
      w = 1'b0;
      chk_on = 1'b1;
      send(25'h1ffffff, 1'b1, 1'b0, 1'b0, 1'b1);
      send(25'h0aaaaaa, 1'b1, 1'b1, 1'b1, 1'b0);
      drain();
      end_sim();
   end
endmodule
`default_nettype wire
